/* File: design/tmrsc_pkg.sv */
`default_nettype none
package tmrsc_pkg;
  // Channel count, pin count and widths
  localparam int NCH = 4;
  localparam int NPIN = 4;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SCR_W = 16;
  // Register indices; byte address is four times the index
  localparam logic [5:0] CH_IDX [NCH] = '{6'h07, 6'h17, 6'h27, 6'h37};
  // Field positions of the channel status/control register
  localparam int BIT_CMP_FLAG = 15;
  localparam int BIT_CMP_IE = 14;
  localparam int BIT_ROLL_FLAG = 13;
  localparam int BIT_ROLL_IE = 12;
  localparam int BIT_EDGE_FLAG = 11;
  localparam int BIT_EDGE_IE = 10;
  localparam int BIT_INV = 9;
  localparam int BIT_INPUT = 8;
  localparam int BIT_CAPM_HI = 7;
  localparam int BIT_CAPM_LO = 6;
  localparam logic [5:0] LOW_RSVD = 6'h00;
  localparam logic [SCR_W-1:0] SCR_RESET = 16'h0000;
  localparam logic [15:0] RDATA_PAD = 16'h0000;
  // Count mode "stopped"
  localparam logic [2:0] CNT_MODE_STOP = 3'h0;
  // Default input filter length in clocks
  localparam int FILT_CNT_DEF = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    CAPM_OFF = 2'h0,
    CAPM_RISE = 2'h1,
    CAPM_FALL = 2'h2,
    CAPM_BOTH = 2'h3
  } tmrsc_capm_t;

  typedef enum logic [0:0]
  {
    BUS_IDLE = 1'h0,
    BUS_RESP = 1'h1
  } tmrsc_bus_st_t;

  // Per-channel view of the counter core
  typedef struct packed {
    logic cmp_match;
    logic rollover;
    logic [2:0] count_mode;
    logic [1:0] src_sel;
    logic [CNT_W-1:0] count;
  } tmrsc_ctr_t;
endpackage
`default_nettype wire

/* File: design/tmrsc_in_cond.sv */
`timescale 1ns/1ps
`default_nettype none
module tmrsc_in_cond #(
  parameter int FILT_CNT = tmrsc_pkg::FILT_CNT_DEF
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [tmrsc_pkg::NPIN-1:0] pins_i,
  input wire logic [1:0] sel_i,
  input wire logic invert_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  localparam int CW = $clog2(FILT_CNT + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CNT - 1);

  logic raw;
  logic level, next_level;
  logic level_d;
  logic [CW-1:0] cnt, next_cnt;

  assign raw = pins_i[sel_i] ^ invert_i;

  // Glitch filter: a new level must persist FILT_CNT clocks
  always_comb
  begin
    next_level = level;
    next_cnt = '0;
    if (raw != level)
    begin
      if (cnt == CNT_LAST)
        next_level = raw;
      else
        next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      level <= 1'b0;
      level_d <= 1'b0;
      cnt <= '0;
    end
    else
    begin
      level <= next_level;
      level_d <= level;
      cnt <= next_cnt;
    end
  end

  // Toggling the invert bit makes an edge too, as on the pin itself
  assign level_o = level;
  assign rise_o = level & ~level_d;
  assign fall_o = ~level & level_d;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  property p_level_src;
    !$stable(level) |-> (level == $past(raw));
  endproperty
  a_level_src: assert property (p_level_src)
    else $error("filtered level changed against its source");
endmodule // tmrsc_in_cond
`default_nettype wire

/* File: design/tmrsc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tmrsc_top #(
  parameter int FILT_CNT = tmrsc_pkg::FILT_CNT_DEF
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [tmrsc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [tmrsc_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [tmrsc_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [tmrsc_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [tmrsc_pkg::NPIN-1:0] ext_pin_i,
  input wire tmrsc_pkg::tmrsc_ctr_t [tmrsc_pkg::NCH-1:0] ctr_i,
  output logic [tmrsc_pkg::NCH-1:0] irq_o,
  output logic [tmrsc_pkg::NCH-1:0][tmrsc_pkg::CNT_W-1:0] capture_o,
  output logic [tmrsc_pkg::NCH-1:0] capture_load_o
);
  localparam int NCH = tmrsc_pkg::NCH;
  localparam int CW = tmrsc_pkg::CNT_W;

  // Returns {hit, channel} for a byte address
  function automatic logic [2:0] decode(input logic [tmrsc_pkg::ADDR_W-1:0] a);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < NCH; i++)
    begin
      if (a == {tmrsc_pkg::CH_IDX[i], 2'h0})
        r = {1'b1, i[1:0]};
    end
    return r;
  endfunction

  // Bus state
  tmrsc_pkg::tmrsc_bus_st_t wr_st, next_wr_st, rd_st, next_rd_st;
  logic aw_full, next_aw_full, w_full, next_w_full;
  logic [tmrsc_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [15:0] w_data, next_w_data;
  logic [1:0] w_strb, next_w_strb;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [tmrsc_pkg::DATA_W-1:0] rdata, next_rdata;
  logic do_write;
  logic [2:0] wdec, rdec;
  logic [NCH-1:0] wr_lo, wr_hi;

  // Channel state
  logic [NCH-1:0] cmp_f, next_cmp_f, cmp_ie, next_cmp_ie;
  logic [NCH-1:0] roll_f, next_roll_f, roll_ie, next_roll_ie;
  logic [NCH-1:0] edge_f, next_edge_f, edge_ie, next_edge_ie;
  logic [NCH-1:0] inv, next_inv;
  tmrsc_pkg::tmrsc_capm_t capm [NCH];
  tmrsc_pkg::tmrsc_capm_t next_capm [NCH];
  logic [NCH-1:0][CW-1:0] cap, next_cap;
  logic [NCH-1:0] cap_ld, next_cap_ld;
  logic [NCH-1:0] lvl, rise, fall, cap_ev;
  logic [NCH-1:0][tmrsc_pkg::SCR_W-1:0] scr;

  for (genvar g = 0; g < NCH; g++)
  begin : g_in
    tmrsc_in_cond #(
      .FILT_CNT(FILT_CNT)
    ) u_in (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .pins_i(ext_pin_i),
      .sel_i(ctr_i[g].src_sel),
      .invert_i(inv[g]),
      .level_o(lvl[g]),
      .rise_o(rise[g]),
      .fall_o(fall[g])
    );
  end

  // live input level in the read view
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      scr[c] = {cmp_f[c], cmp_ie[c], roll_f[c], roll_ie[c], edge_f[c], edge_ie[c],
                inv[c], lvl[c], capm[c], tmrsc_pkg::LOW_RSVD};
    end
  end

  // Write path: address and data taken in either order, committed together
  assign wdec = decode(aw_addr);
  assign rdec = decode(s_axi_araddr_i);
  assign s_axi_awready_o = ~aw_full;
  assign s_axi_wready_o = ~w_full;
  assign s_axi_bvalid_o = (wr_st == tmrsc_pkg::BUS_RESP);
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = (rd_st == tmrsc_pkg::BUS_IDLE);
  assign s_axi_rvalid_o = (rd_st == tmrsc_pkg::BUS_RESP);
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;

  always_comb
  begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_wr_st = wr_st;
    next_bresp = bresp;
    do_write = 1'b0;
    if (s_axi_awvalid_i && !aw_full)
    begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !w_full)
    begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata_i[15:0];
      next_w_strb = s_axi_wstrb_i[1:0];
    end
    case (wr_st)
      tmrsc_pkg::BUS_IDLE:
      begin
        if (aw_full && w_full)
        begin
          do_write = wdec[2];
          next_bresp = wdec[2] ? tmrsc_pkg::RESP_OKAY : tmrsc_pkg::RESP_SLVERR;
          next_aw_full = 1'b0;
          next_w_full = 1'b0;
          next_wr_st = tmrsc_pkg::BUS_RESP;
        end
      end
      tmrsc_pkg::BUS_RESP:
      begin
        if (s_axi_bready_i)
          next_wr_st = tmrsc_pkg::BUS_IDLE;
      end
      default:
        next_wr_st = tmrsc_pkg::BUS_IDLE;
    endcase
  end

  // Upper byte lane holds flags and enables, lower holds the capture mode
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      wr_lo[c] = do_write && (wdec[1:0] == c[1:0]) && w_strb[0];
      wr_hi[c] = do_write && (wdec[1:0] == c[1:0]) && w_strb[1];
    end
  end

  // Read path: one cycle to answer, unmapped gives SLVERR and zero
  // register decode
  always_comb
  begin
    next_rd_st = rd_st;
    next_rdata = rdata;
    next_rresp = rresp;
    case (rd_st)
      tmrsc_pkg::BUS_IDLE:
      begin
        if (s_axi_arvalid_i)
        begin
          next_rd_st = tmrsc_pkg::BUS_RESP;
          next_rdata = '0;
          next_rresp = tmrsc_pkg::RESP_SLVERR;
          if (rdec[2])
          begin
            next_rdata = {tmrsc_pkg::RDATA_PAD, scr[rdec[1:0]]};
            next_rresp = tmrsc_pkg::RESP_OKAY;
          end
        end
      end
      tmrsc_pkg::BUS_RESP:
      begin
        if (s_axi_rready_i)
          next_rd_st = tmrsc_pkg::BUS_IDLE;
      end
      default:
        next_rd_st = tmrsc_pkg::BUS_IDLE;
    endcase
  end

  // Channel logic; a hardware set wins over a clear in the same cycle
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      next_cmp_f[c] = (cmp_f[c] & ~(wr_hi[c] & ~w_data[tmrsc_pkg::BIT_CMP_FLAG]))
                      | ctr_i[c].cmp_match;
      next_roll_f[c] = (roll_f[c] & ~(wr_hi[c] & ~w_data[tmrsc_pkg::BIT_ROLL_FLAG]))
                       | ctr_i[c].rollover;
      // edge flag, gated by count mode
      next_edge_f[c] = (edge_f[c] & ~(wr_hi[c] & ~w_data[tmrsc_pkg::BIT_EDGE_FLAG]))
                       | (rise[c] && ctr_i[c].count_mode != tmrsc_pkg::CNT_MODE_STOP);
      next_cmp_ie[c] = wr_hi[c] ? w_data[tmrsc_pkg::BIT_CMP_IE] : cmp_ie[c];
      next_roll_ie[c] = wr_hi[c] ? w_data[tmrsc_pkg::BIT_ROLL_IE] : roll_ie[c];
      next_edge_ie[c] = wr_hi[c] ? w_data[tmrsc_pkg::BIT_EDGE_IE] : edge_ie[c];
      next_inv[c] = wr_hi[c] ? w_data[tmrsc_pkg::BIT_INV] : inv[c];
      next_capm[c] = wr_lo[c] ?
        tmrsc_pkg::tmrsc_capm_t'(w_data[tmrsc_pkg::BIT_CAPM_HI:tmrsc_pkg::BIT_CAPM_LO]) :
        capm[c];
      case (capm[c])
        tmrsc_pkg::CAPM_OFF: cap_ev[c] = 1'b0;
        tmrsc_pkg::CAPM_RISE: cap_ev[c] = rise[c];
        tmrsc_pkg::CAPM_FALL: cap_ev[c] = fall[c];
        tmrsc_pkg::CAPM_BOTH: cap_ev[c] = rise[c] | fall[c];
        default: cap_ev[c] = 1'b0;
      endcase
      next_cap[c] = cap_ev[c] ? ctr_i[c].count : cap[c];
      next_cap_ld[c] = cap_ev[c];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      wr_st <= tmrsc_pkg::BUS_IDLE;
      rd_st <= tmrsc_pkg::BUS_IDLE;
      aw_full <= 1'b0;
      aw_addr <= '0;
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      bresp <= tmrsc_pkg::RESP_OKAY;
      rresp <= tmrsc_pkg::RESP_OKAY;
      rdata <= '0;
      cmp_f <= '0;
      cmp_ie <= '0;
      roll_f <= '0;
      roll_ie <= '0;
      edge_f <= '0;
      edge_ie <= '0;
      inv <= '0;
      capm <= '{default: tmrsc_pkg::CAPM_OFF};
      cap <= '0;
      cap_ld <= '0;
    end
    else
    begin
      wr_st <= next_wr_st;
      rd_st <= next_rd_st;
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bresp <= next_bresp;
      rresp <= next_rresp;
      rdata <= next_rdata;
      cmp_f <= next_cmp_f;
      cmp_ie <= next_cmp_ie;
      roll_f <= next_roll_f;
      roll_ie <= next_roll_ie;
      edge_f <= next_edge_f;
      edge_ie <= next_edge_ie;
      inv <= next_inv;
      capm <= next_capm;
      cap <= next_cap;
      cap_ld <= next_cap_ld;
    end
  end

  assign irq_o = (cmp_f & cmp_ie) | (roll_f & roll_ie) | (edge_f & edge_ie);
  assign capture_o = cap;
  assign capture_load_o = cap_ld;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  sequence s_ar_bad;
    s_axi_arvalid_i && s_axi_arready_o && !rdec[2];
  endsequence
  sequence s_ar_ch0;
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == {tmrsc_pkg::CH_IDX[0], 2'h0};
  endsequence

  property p_rd_unmapped;
    s_ar_bad |=> s_axi_rvalid_o && s_axi_rresp_o == tmrsc_pkg::RESP_SLVERR
                 && s_axi_rdata_o == '0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not refused");

  property p_rd_ch0;
    s_ar_ch0 ##1 1'b1 |-> s_axi_rresp_o == tmrsc_pkg::RESP_OKAY
      && s_axi_rdata_o[tmrsc_pkg::BIT_CMP_FLAG] == $past(cmp_f[0]);
  endproperty
  a_rd_ch0: assert property (p_rd_ch0)
    else $error("channel 0 read returned wrong word");

  for (genvar g = 0; g < NCH; g++)
  begin : g_chk
    property p_cmp_set;
      ctr_i[g].cmp_match |=> cmp_f[g] ##1 (cmp_f[g] || $past(wr_hi[g]));
    endproperty
    a_cmp_set: assert property (p_cmp_set)
      else $error("compare flag not held after match");

    property p_cmp_clr;
      wr_hi[g] && !w_data[tmrsc_pkg::BIT_CMP_FLAG] && !ctr_i[g].cmp_match |=> !cmp_f[g];
    endproperty
    a_cmp_clr: assert property (p_cmp_clr)
      else $error("compare flag not cleared by zero write");

    property p_roll_set;
      ctr_i[g].rollover |=> roll_f[g];
    endproperty
    a_roll_set: assert property (p_roll_set)
      else $error("rollover flag not set");

    property p_edge_set;
      rise[g] && ctr_i[g].count_mode != tmrsc_pkg::CNT_MODE_STOP |=> edge_f[g];
    endproperty
    a_edge_set: assert property (p_edge_set)
      else $error("edge flag not set on rising input");

    property p_edge_stop;
      !edge_f[g] && ctr_i[g].count_mode == tmrsc_pkg::CNT_MODE_STOP |=> !edge_f[g];
    endproperty
    a_edge_stop: assert property (p_edge_stop)
      else $error("edge flag set while count mode is stopped");

    property p_flag_keep;
      wr_hi[g] && w_data[tmrsc_pkg::BIT_ROLL_FLAG] && roll_f[g] |=> roll_f[g];
    endproperty
    a_flag_keep: assert property (p_flag_keep)
      else $error("writing one disturbed rollover flag");

    property p_irq_cmp;
      cmp_f[g] && cmp_ie[g] |-> irq_o[g];
    endproperty
    a_irq_cmp: assert property (p_irq_cmp)
      else $error("compare interrupt missing");

    property p_irq_roll;
      roll_f[g] && roll_ie[g] |-> irq_o[g];
    endproperty
    a_irq_roll: assert property (p_irq_roll)
      else $error("rollover interrupt missing");

    property p_irq_edge;
      edge_f[g] && edge_ie[g] |-> irq_o[g];
    endproperty
    a_irq_edge: assert property (p_irq_edge)
      else $error("edge interrupt missing");

    property p_irq_quiet;
      !(cmp_f[g] && cmp_ie[g]) && !(roll_f[g] && roll_ie[g]) && !(edge_f[g] && edge_ie[g])
        |-> !irq_o[g];
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
      else $error("interrupt without enabled flag");

    property p_cap_off;
      capm[g] == tmrsc_pkg::CAPM_OFF |=> !capture_load_o[g];
    endproperty
    a_cap_off: assert property (p_cap_off)
      else $error("capture loaded while disabled");

    property p_cap_rise;
      capm[g] == tmrsc_pkg::CAPM_RISE && rise[g]
        |=> capture_load_o[g] && capture_o[g] == $past(ctr_i[g].count);
    endproperty
    a_cap_rise: assert property (p_cap_rise)
      else $error("capture missed on mode 01 edge");

    property p_cap_fall;
      capm[g] == tmrsc_pkg::CAPM_FALL |=> capture_load_o[g] == $past(fall[g]);
    endproperty
    a_cap_fall: assert property (p_cap_fall)
      else $error("mode 10 capture on wrong edge");
  end
endmodule // tmrsc_top
`default_nettype wire

/* File: dv/tmrsc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tmrsc_far_model (
  input wire logic mclk_i,
  input wire logic [3:0] cmp_req_i,
  input wire logic [3:0] roll_req_i,
  input wire logic [3:0] pin_req_i,
  input wire logic [3:0][2:0] mode_i,
  input wire logic [3:0][1:0] sel_i,
  input wire logic [15:0] count_i,
  output logic [3:0] pins_o,
  output tmrsc_pkg::tmrsc_ctr_t [3:0] ctr_o
);
  // Counter core and pin synchronisers both launch on the clock edge, never mid-cycle
  always @(posedge mclk_i)
  begin
    pins_o <= pin_req_i;
    for (int c = 0; c < 4; c++)
    begin
      ctr_o[c].cmp_match <= cmp_req_i[c];
      ctr_o[c].rollover <= roll_req_i[c];
      ctr_o[c].count_mode <= mode_i[c];
      ctr_o[c].src_sel <= sel_i[c];
      // Count held still so a capture has one right answer
      ctr_o[c].count <= count_i;
    end
  end
endmodule // tmrsc_far_model
`default_nettype wire

/* File: dv/tb_timer_channel_status_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel_status_control;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] irq, cap_load, pins;
  logic [3:0] strb = 4'h3;
  logic [3:0] cmp_req = 4'h0;
  logic [3:0] roll_req = 4'h0;
  logic [3:0] pin_req = 4'h0;
  logic [3:0][2:0] cmode_r = {4{3'h1}};
  logic [3:0][1:0] sel_r = {2'h3, 2'h2, 2'h1, 2'h0};
  logic [15:0] cnt_r = 16'h0000;
  logic [3:0][15:0] cap;
  tmrsc_pkg::tmrsc_ctr_t [3:0] ctr;
  logic [31:0] d;
  logic [1:0] r;
  int seed = 47108;
  int miscompares = 0;
  int checks_done = 0;
  int regm [4] = '{0, 0, 0, 0};
  int lvl [4] = '{0, 0, 0, 0};
  int loads [4] = '{0, 0, 0, 0};
  int got_loads [4] = '{0, 0, 0, 0};

  always #12.5 mclk_i = ~mclk_i;

  tmrsc_top #(.FILT_CNT(1)) tmrsc_top_inst (
    .mclk_i(mclk_i), .srst_i(srst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ext_pin_i(pins), .ctr_i(ctr),
    .irq_o(irq), .capture_o(cap), .capture_load_o(cap_load));

  tmrsc_far_model tmrsc_far_model_inst (
    .mclk_i(mclk_i), .cmp_req_i(cmp_req), .roll_req_i(roll_req), .pin_req_i(pin_req),
    .mode_i(cmode_r), .sel_i(sel_r), .count_i(cnt_r), .pins_o(pins), .ctr_o(ctr));

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 200)
    begin
      miscompares++;
      results();
    end
  endtask

  always @(posedge mclk_i)
  begin
    for (int c = 0; c < 4; c++)
    begin
      if (cap_load[c] === 1'b1)
      begin
        got_loads[c]++;
        cmp(32'(cap[c]), 32'(cnt_r));
      end
    end
  end

  task automatic axw(input logic [7:0] a, input logic [15:0] v, output logic [1:0] rs);
    int n = 0;
    logic bd = 1'b0;
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= {16'($random(seed)), v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bd && n < 200)
    begin
      @(posedge mclk_i);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        bd = 1'b1;
        rs = bresp;
        bready <= 1'b0;
      end
    end
    tmo(bd ? 0 : n);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n = 0;
    logic done = 1'b0;
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 200)
    begin
      @(posedge mclk_i);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        done = 1'b1;
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
    tmo(done ? 0 : n);
  endtask

  function automatic logic [7:0] adr(input int c);
    return {tmrsc_pkg::CH_IDX[c], 2'b00};
  endfunction

  // Model: conditioned level is the selected pin xor invert; rising edges drive flag, capture mode picks edges for capture
  task automatic upd(input int c);
    int nl = int'(pin_req[sel_r[c]]) ^ ((regm[c] >> 9) & 1);
    if (nl > lvl[c] && cmode_r[c] != 3'h0)
      regm[c] |= 'h800;
    if ((nl > lvl[c] && (regm[c] & 'h40) != 0) || (nl < lvl[c] && (regm[c] & 'h80) != 0))
      loads[c]++;
    lvl[c] = nl;
  endtask

  task automatic wr(input int c, input int v);
    int keep;
    axw(adr(c), 16'(v), r);
    cmp(32'(r), 32'(tmrsc_pkg::RESP_OKAY));
    // Flags only clear on zero; a lane without its strobe keeps its bits
    keep = (strb[1] ? 0 : 16'hFF00) | (strb[0] ? 0 : 16'h00C0);
    regm[c] = (regm[c] & keep) | (~keep & ((regm[c] & v & 16'hA800) | (v & 16'h56C0)));
    upd(c);
    repeat (4) @(posedge mclk_i);
  endtask

  task automatic chk(input int c);
    logic [3:0] e;
    axr(adr(c), d, r);
    cmp(32'(r), 32'(tmrsc_pkg::RESP_OKAY));
    cmp(d, 32'(regm[c] | (lvl[c] << 8)));
    cmp(32'(got_loads[c]), 32'(loads[c]));
    for (int k = 0; k < 4; k++)
      e[k] = 1'((regm[k] >> 15 & regm[k] >> 14 | regm[k] >> 13 & regm[k] >> 12
        | regm[k] >> 11 & regm[k] >> 10) & 1);
    cmp(32'(irq), 32'(e));
  endtask

  task automatic pulse(input int c, input logic cmp_not_roll);
    @(posedge mclk_i);
    cmp_req[c] <= cmp_not_roll;
    roll_req[c] <= !cmp_not_roll;
    @(posedge mclk_i);
    cmp_req[c] <= 1'b0;
    roll_req[c] <= 1'b0;
    regm[c] |= cmp_not_roll ? 'h8000 : 'h2000;
    repeat (3) @(posedge mclk_i);
  endtask

  task automatic setpin(input int p, input logic v);
    @(posedge mclk_i);
    pin_req[p] <= v;
    @(posedge mclk_i);
    for (int c = 0; c < 4; c++)
      if (sel_r[c] == 2'(p))
        upd(c);
    repeat (4) @(posedge mclk_i);
  endtask

  initial
  begin
    repeat (16) @(posedge mclk_i);
    srst_i <= 1'b0;
    for (int c = 0; c < 4; c++)
      chk(c);
    axr(8'h00, d, r);
    cmp(32'(r), 32'(tmrsc_pkg::RESP_SLVERR));
    cmp(d, 32'h0000_0000);
    axw(8'h20, 16'hFFFF, r);
    cmp(32'(r), 32'(tmrsc_pkg::RESP_SLVERR));
    for (int c = 0; c < 4; c++)
    begin
      pulse(c, 1'b1);
      chk(c);
      pulse(c, 1'b0);
      chk(c);
      setpin(c, 1'b1);
      chk(c);
      wr(c, 16'hA800 | (1 << (10 + 2 * (c % 3))));
      chk(c);
      wr(c, 16'h5400);
      chk(c);
      pulse(c, 1'b1);
      chk(c);
      wr(c, 0);
      chk(c);
    end
    // Channel 0 moves to pin 2, then inverts it
    @(posedge mclk_i);
    sel_r[0] <= 2'h2;
    setpin(2, 1'b1);
    wr(0, 16'h0200);
    chk(0);
    setpin(2, 1'b0);
    chk(0);
    setpin(0, 1'b0);
    chk(0);
    @(posedge mclk_i);
    cmode_r[1] <= tmrsc_pkg::CNT_MODE_STOP;
    setpin(1, 1'b0);
    setpin(1, 1'b1);
    chk(1);
    for (int m = 0; m < 8; m++)
    begin
      cnt_r <= 16'($random(seed));
      wr(3, ((m & 1) << 9) | ((m >> 1) << 6));
      setpin(3, !pin_req[3]);
      chk(3);
      setpin(3, !pin_req[3]);
      chk(3);
    end
    // Lane strobes: the low lane alone sets the mode, the high lane alone leaves it
    strb <= 4'h1;
    wr(2, 16'hFFC0);
    chk(2);
    strb <= 4'h2;
    wr(2, 16'h5440);
    chk(2);
    setpin(2, 1'b1);
    chk(2);
    results();
  end
endmodule // tb_timer_channel_status_control
`default_nettype wire
